/* File: verilog/ufbl_pkg.sv */
// Shared constants, types and helpers for the fractional-baud serial port
package ufbl_pkg;

  // ----------------------------------------
  // Sizes and reset defaults
  // ----------------------------------------
  localparam int FIFO_DEPTH = 480;
  localparam int FIFO_AW = 9;
  localparam int FIFO_W = 9;
  localparam logic [FIFO_AW-1:0] RTS_LEVEL = 9'h1d0; // Depth less 16 bytes
  localparam logic [7:0] CLKDIV_RST = 8'hf3;
  localparam logic [7:0] STUFF_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] STUFF_MAX = 4'h8;
  localparam logic [8:0] DIV_SPAN = 9'h100;
  localparam logic [3:0] FLUSH_BITS = 4'ha;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CDIV = 8'h0c;
  localparam logic [7:0] ADDR_STUF = 8'h10;
  localparam logic [7:0] ADDR_ISTA = 8'h14;
  localparam logic [7:0] ADDR_IMSK = 8'h18;

  // ----------------------------------------
  // Control bits and interrupt bits
  // ----------------------------------------
  localparam int C_AUTO = 0;
  localparam int C_SWFL = 1;
  localparam int C_HWFL = 2;
  localparam int C_SLIP = 3;
  localparam int C_SLEEP = 4;
  localparam int I_RXB = 0;
  localparam int I_FERR = 1;
  localparam int I_OVR = 2;
  localparam int I_FRAME = 3;
  localparam int I_ABD = 4;
  localparam int I_WAKE = 5;
  localparam int I_TXD = 6;
  localparam int INT_W = 7;

  // ----------------------------------------
  // Special characters
  // ----------------------------------------
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] SLIP_END = 8'hc0;
  localparam logic [7:0] SLIP_ESC = 8'hdb;
  localparam logic [7:0] SLIP_EEND = 8'hdc;
  localparam logic [7:0] SLIP_EESC = 8'hdd;

  typedef enum logic [2:0] {RX_IDLE, RX_MEAS, RX_START, RX_DATA, RX_STOP, RX_FLUSH} ufbl_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ufbl_tx_e;

  // Effective divisor from the stored complement
  function automatic logic [8:0] eff_div(input logic [7:0] v);
    return DIV_SPAN - {1'b0, v};
  endfunction

  // Stuffing count limited to its ceiling
  function automatic logic [3:0] sat_nib(input logic [3:0] v);
    return (v > STUFF_MAX) ? STUFF_MAX : v;
  endfunction

  // Half-bit length: eight times the divisor plus stuffing
  function automatic logic [12:0] half_len(input logic [8:0] d, input logic [3:0] s);
    return {1'b0, d, 3'h0} + {9'h000, s};
  endfunction

endpackage

/* File: verilog/ufbl_fifo.sv */
// Flip-flop queue with valid/ready on both sides
`timescale 1ns/1ps
module ufbl_fifo import ufbl_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH,
  parameter int AW = FIFO_AW
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  // Fill level
  output logic [AW-1:0] count
);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW-1:0] cnt_q;
  logic push;
  logic pop;

  // Pointer step with wrap at the non-power-of-two depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // Handshake terms
  assign in_ready = (cnt_q != AW'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign count = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= step(wp_q);
      end
      if (pop) begin
        rp_q <= step(rp_q);
      end
      cnt_q <= cnt_q + AW'(push) - AW'(pop);
    end
  end

  level_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cnt_q <= AW'(D))
    else $error("queue level above depth");

  full_refuse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cnt_q == AW'(D)) && !out_ready |=> cnt_q == AW'(D))
    else $error("full queue changed level without a drain");

endmodule // ufbl_fifo

/* File: verilog/ufbl_baud.sv */
// Bit timer: half-bit and full-bit pulses from divisor and stuffing
`timescale 1ns/1ps
module ufbl_baud import ufbl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Timing control
  input wire logic run,
  input wire logic [7:0] clk_div,
  input wire logic [7:0] baud_stuff,
  // Timing pulses
  output logic mid_q,
  output logic end_q
);

  logic [8:0] div;
  logic [12:0] len1;
  logic [12:0] len2;
  logic [12:0] last;
  logic [12:0] cnt_q;
  logic half_q;
  logic [12:0] gap_q;
  logic seen_q;

  // Half lengths: upper nibble pads first half, lower the second
  assign div = eff_div(clk_div);
  assign len1 = half_len(div, sat_nib(baud_stuff[7:4]));
  assign len2 = half_len(div, sat_nib(baud_stuff[3:0]));
  assign last = (half_q ? len2 : len1) - 13'h001;

  // Counter restarts whenever run drops
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      cnt_q <= '0;
      half_q <= 1'b0;
      mid_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      mid_q <= 1'b0;
      end_q <= 1'b0;
      if (cnt_q == last) begin
        cnt_q <= '0;
        half_q <= ~half_q;
        mid_q <= ~half_q;
        end_q <= half_q;
      end else begin
        cnt_q <= cnt_q + 13'h001;
      end
    end
  end

  // Checking aid: cycles since the last bit end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !run) begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= end_q ? 13'h001 : gap_q + 13'h001;
      seen_q <= seen_q | end_q;
    end
  end

  bit_length_a: assert property (@(posedge ref_clk) disable iff (sys_rst || !run)
    end_q && seen_q |-> gap_q == {div, 4'h0}
      + ((baud_stuff[7:4] > 4'h8) ? 13'h008 : {9'h000, baud_stuff[7:4]})
      + ((baud_stuff[3:0] > 4'h8) ? 13'h008 : {9'h000, baud_stuff[3:0]}))
    else $error("bit length differs from divisor and stuffing");

  mid_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst || !run)
    mid_q |-> !end_q ##1 !mid_q)
    else $error("half-bit pulse malformed");

endmodule // ufbl_baud

/* File: verilog/ufbl_top.sv */
// Four-wire serial port with fractional baud, queues, flow control, SLIP and wake
`timescale 1ns/1ps

// Overview of operation
// - Four-wire port, 9600 bps to 1.5 Mbps
// - Detect incoming rate or use preset rate
// - Separate 480-byte receive and transmit queues
// - XOFF pauses transmit, XON resumes it
// - SLIP framing: delimit frames, escape reserved bytes
// - Receive or clear-to-send activity wakes sleep
// - Bit timing divides reference by sixteen multiples
// - Divisor stored as 256 minus wanted value
// - Stuffing nibbles pad first and second half
// - Stuffing nibble above 8 counts as 8
// - Rate comes from stored defaults, register writes or detection
// - Combined rate error within five percent
module ufbl_top import ufbl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB register port
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  // System signals
  output logic irq,
  output logic wake_req
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] ctrl_q, clk_div_q, stuff_q;
  logic [INT_W-1:0] int_stat_q, int_mask_q, int_set;
  logic [31:0] prdata_q, rd_val;
  logic pready_q, pslverr_q, rd_ok, wr, rd;
  logic [2:0] rx_s_q, cts_s_q;
  logic rx_lvl_q, rx_prev_q, cts_lvl_q, cts_prev_q, rx_fall;
  ufbl_rx_e rx_st_q;
  ufbl_tx_e tx_st_q;
  logic [3:0] rx_idx_q;
  logic [7:0] rx_sr_q, rx_byte_q;
  logic rx_got_q, ferr_q, rx_mid, rx_end, rx_run;
  logic [15:0] ab_cnt_q;
  logic [16:0] ab_n;
  logic [8:0] ab_div;
  logic ab_arm_q, ab_done_q;
  logic esc_q, xoff_q, rx_wvalid, rx_in_ready;
  logic [8:0] rx_wdata, rx_head, tx_head;
  logic [FIFO_AW-1:0] rx_count;
  logic rx_pop, rx_avail, tx_push, tx_in_ready, tx_avail, tx_pop;
  logic [7:0] tx_sr_q, tx_pend_q;
  logic [2:0] tx_idx_q;
  logic tx_pend_v_q, tx_done_q, txd_q, tx_end, tx_ok, tx_esc;
  logic rts_n_q, irq_q, wake_q, wake_ev;

  // ----------------------------------------
  // APB slave, one registered access cycle
  // ----------------------------------------
  assign wr = psel & penable & pready_q & pwrite;
  assign rd = psel & penable & pready_q & ~pwrite;

  // Read mux and address check
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    unique case (paddr)
      ADDR_DATA: rd_val = {rx_avail, 22'h000000, rx_head};
      ADDR_STAT: rd_val = {7'h00, rx_count, 8'h00, rts_n_q, cts_lvl_q, tx_st_q != TX_IDLE,
                           rx_st_q != RX_IDLE, ab_arm_q, xoff_q, ~tx_in_ready, ~rx_avail};
      ADDR_CTRL: rd_val = {24'h000000, ctrl_q};
      ADDR_CDIV: rd_val = {24'h000000, clk_div_q};
      ADDR_STUF: rd_val = {24'h000000, stuff_q};
      ADDR_ISTA: rd_val = {25'h0000000, int_stat_q};
      ADDR_IMSK: rd_val = {25'h0000000, int_mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  // Answer prepared in setup, shown in access
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & (~rd_ok | (pwrite & (paddr == ADDR_DATA) & ~tx_in_ready));
      prdata_q <= (psel & ~penable & ~pwrite) ? rd_val : '0;
    end
  end

  // Software registers; detection overwrites the rate
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      clk_div_q <= CLKDIV_RST;
      stuff_q <= STUFF_RST;
      int_mask_q <= '0;
      ab_arm_q <= CTRL_RST[C_AUTO];
    end else begin
      if (wr && paddr == ADDR_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wr && paddr == ADDR_IMSK) begin
        int_mask_q <= pwdata[INT_W-1:0];
      end
      if (ab_done_q) begin
        clk_div_q <= 8'(DIV_SPAN - ab_div);
        stuff_q <= STUFF_RST;
        ab_arm_q <= 1'b0;
      end else begin
        if (wr && paddr == ADDR_CDIV) begin
          clk_div_q <= pwdata[7:0];
        end
        if (wr && paddr == ADDR_STUF) begin
          stuff_q <= pwdata[7:0];
        end
        if (wr && paddr == ADDR_CTRL) begin
          ab_arm_q <= pwdata[C_AUTO];
        end
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers and wake
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_s_q <= 3'h7;
      cts_s_q <= '0; // Clear-to-send idles low: no false edge after reset
      rx_lvl_q <= 1'b1;
      cts_lvl_q <= 1'b0;
      rx_prev_q <= 1'b1;
      cts_prev_q <= 1'b0;
    end else begin
      rx_s_q <= {rx_s_q[1:0], rxd};
      cts_s_q <= {cts_s_q[1:0], cts_n};
      if (rx_s_q[1] == rx_s_q[2]) begin
        rx_lvl_q <= rx_s_q[2];
      end
      if (cts_s_q[1] == cts_s_q[2]) begin
        cts_lvl_q <= cts_s_q[2];
      end
      rx_prev_q <= rx_lvl_q;
      cts_prev_q <= cts_lvl_q;
    end
  end

  assign rx_fall = rx_prev_q & ~rx_lvl_q;
  assign wake_ev = ctrl_q[C_SLEEP] & ((rx_prev_q ^ rx_lvl_q) | (cts_prev_q ^ cts_lvl_q));

  // Wake request stands until sleep is left
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ctrl_q[C_SLEEP] & (wake_q | wake_ev);
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign rx_run = (rx_st_q != RX_IDLE) && (rx_st_q != RX_MEAS);
  assign ab_n = ({1'b0, ab_cnt_q} + 17'h00008) >> 4;
  assign ab_div = (ab_n == '0) ? 9'h001 : ((ab_n > 17'h00100) ? DIV_SPAN : ab_n[8:0]);

  ufbl_baud u_rx_baud (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(rx_run),
    .clk_div(clk_div_q),
    .baud_stuff(stuff_q),
    .mid_q(rx_mid),
    .end_q(rx_end)
  );

  // Receive state machine; bits sampled at mid-bit for rate margin
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_st_q <= RX_IDLE;
      rx_idx_q <= '0;
      rx_sr_q <= '0;
      rx_byte_q <= '0;
      rx_got_q <= 1'b0;
      ferr_q <= 1'b0;
      ab_cnt_q <= '0;
      ab_done_q <= 1'b0;
    end else begin
      rx_got_q <= 1'b0;
      ferr_q <= 1'b0;
      ab_done_q <= 1'b0;
      unique case (rx_st_q)
        RX_IDLE: begin
          ab_cnt_q <= '0;
          if (rx_fall) begin
            rx_st_q <= ab_arm_q ? RX_MEAS : RX_START;
          end
        end
        RX_MEAS: begin
          if (ab_cnt_q != 16'hffff) begin
            ab_cnt_q <= ab_cnt_q + 16'h0001;
          end
          if (rx_lvl_q) begin
            ab_done_q <= 1'b1;
            rx_idx_q <= '0;
            rx_st_q <= RX_FLUSH;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_idx_q <= '0;
            rx_st_q <= rx_lvl_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sr_q <= {rx_lvl_q, rx_sr_q[7:1]};
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q[2:0] == LAST_BIT) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_got_q <= rx_lvl_q;
            ferr_q <= ~rx_lvl_q;
            rx_byte_q <= rx_sr_q;
            rx_st_q <= RX_IDLE;
          end
        end
        RX_FLUSH: begin
          if (!rx_lvl_q) begin
            rx_idx_q <= '0;
          end else if (rx_end) begin
            rx_idx_q <= rx_idx_q + 4'h1;
          end
          if (rx_idx_q == FLUSH_BITS) begin
            rx_st_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Flow characters are consumed; SLIP bytes decoded before queueing
  always_comb begin
    rx_wvalid = rx_got_q;
    rx_wdata = {1'b0, rx_byte_q};
    if (ctrl_q[C_SWFL] && (rx_byte_q == CH_XON || rx_byte_q == CH_XOFF)) begin
      rx_wvalid = 1'b0;
    end else if (ctrl_q[C_SLIP]) begin
      if (rx_byte_q == SLIP_END) begin
        rx_wdata = {1'b1, SLIP_END};
      end else if (rx_byte_q == SLIP_ESC) begin
        rx_wvalid = 1'b0;
      end else if (esc_q && rx_byte_q == SLIP_EEND) begin
        rx_wdata = {1'b0, SLIP_END};
      end else if (esc_q && rx_byte_q == SLIP_EESC) begin
        rx_wdata = {1'b0, SLIP_ESC};
      end
    end
  end

  // Escape and pause state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      esc_q <= 1'b0;
      xoff_q <= 1'b0;
    end else begin
      if (rx_got_q && ctrl_q[C_SLIP]) begin
        esc_q <= (rx_byte_q == SLIP_ESC);
      end
      if (!ctrl_q[C_SWFL]) begin
        xoff_q <= 1'b0;
      end else if (rx_got_q && rx_byte_q == CH_XOFF) begin
        xoff_q <= 1'b1;
      end else if (rx_got_q && rx_byte_q == CH_XON) begin
        xoff_q <= 1'b0;
      end
    end
  end

  assign rx_pop = rd & (paddr == ADDR_DATA) & rx_avail;

  ufbl_fifo u_rx_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(rx_wvalid),
    .in_data(rx_wdata),
    .in_ready(rx_in_ready),
    .out_valid(rx_avail),
    .out_data(rx_head),
    .out_ready(rx_pop),
    .count(rx_count)
  );

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_push = wr & (paddr == ADDR_DATA);
  assign tx_ok = !(ctrl_q[C_HWFL] && cts_lvl_q) && !xoff_q;
  assign tx_pop = (tx_st_q == TX_IDLE) & tx_ok & ~tx_pend_v_q;
  assign tx_esc = ctrl_q[C_SLIP] & ~tx_head[8] &
                  ((tx_head[7:0] == SLIP_END) | (tx_head[7:0] == SLIP_ESC));

  ufbl_fifo u_tx_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(tx_push),
    .in_data(pwdata[8:0]),
    .in_ready(tx_in_ready),
    .out_valid(tx_avail),
    .out_data(tx_head),
    .out_ready(tx_pop),
    .count()
  );

  ufbl_baud u_tx_baud (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(tx_st_q != TX_IDLE),
    .clk_div(clk_div_q),
    .baud_stuff(stuff_q),
    .mid_q(),
    .end_q(tx_end)
  );

  // Transmit state machine; new characters start only when allowed
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_st_q <= TX_IDLE;
      tx_sr_q <= '0;
      tx_pend_q <= '0;
      tx_pend_v_q <= 1'b0;
      tx_idx_q <= '0;
      tx_done_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      tx_done_q <= 1'b0;
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_ok && tx_pend_v_q) begin
            tx_sr_q <= tx_pend_q;
            tx_pend_v_q <= 1'b0;
            tx_st_q <= TX_START;
          end else if (tx_pop && tx_avail) begin
            tx_sr_q <= tx_esc ? SLIP_ESC : tx_head[7:0];
            tx_pend_q <= (tx_head[7:0] == SLIP_END) ? SLIP_EEND : SLIP_EESC;
            tx_pend_v_q <= tx_esc;
            tx_st_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_end) begin
            txd_q <= tx_sr_q[0];
            tx_idx_q <= '0;
            tx_st_q <= TX_DATA;
          end else begin
            txd_q <= 1'b0;
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            tx_idx_q <= tx_idx_q + 3'h1;
            tx_sr_q <= {1'b0, tx_sr_q[7:1]};
            txd_q <= (tx_idx_q == LAST_BIT) ? 1'b1 : tx_sr_q[1];
            if (tx_idx_q == LAST_BIT) begin
              tx_st_q <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            tx_done_q <= 1'b1;
            tx_st_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Handshake, interrupts and outputs
  // ----------------------------------------
  always_comb begin
    int_set = '0;
    int_set[I_RXB] = rx_wvalid & rx_in_ready;
    int_set[I_FERR] = ferr_q;
    int_set[I_OVR] = rx_wvalid & ~rx_in_ready;
    int_set[I_FRAME] = rx_wvalid & rx_wdata[8];
    int_set[I_ABD] = ab_done_q;
    int_set[I_WAKE] = wake_ev;
    int_set[I_TXD] = tx_done_q;
  end

  // Sticky status: a new event beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_stat_q <= '0;
      irq_q <= 1'b0;
      rts_n_q <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~((wr && paddr == ADDR_ISTA) ? pwdata[INT_W-1:0] : '0))
                    | int_set;
      irq_q <= |(int_stat_q & int_mask_q);
      rts_n_q <= ctrl_q[C_HWFL] & (rx_count >= RTS_LEVEL);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txd = txd_q;
  assign rts_n = rts_n_q;
  assign irq = irq_q;
  assign wake_req = wake_q;

  rts_full_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ctrl_q[C_HWFL] && rx_count >= RTS_LEVEL |=> rts_n_q)
    else $error("request-to-send not dropped near full");

  cts_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tx_st_q == TX_IDLE && ctrl_q[C_HWFL] && cts_lvl_q |=> tx_st_q == TX_IDLE)
    else $error("character started while clear-to-send off");

  xoff_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tx_st_q == TX_IDLE && xoff_q |=> tx_st_q == TX_IDLE)
    else $error("character started while paused");

  flow_drop_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_got_q && ctrl_q[C_SWFL] && rx_byte_q == CH_XOFF |-> !rx_wvalid ##1 xoff_q)
    else $error("pause character queued or ignored");

  start_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(tx_st_q == TX_START) |=> !txd_q [*2])
    else $error("start bit not low");

  wake_flag_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wake_ev |=> int_stat_q[I_WAKE] && wake_q)
    else $error("activity in sleep did not wake");

  rate_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ab_done_q |=> eff_div(clk_div_q) == $past(ab_div) && !ab_arm_q)
    else $error("detected rate not loaded");

  slip_esc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tx_pop && tx_avail && tx_esc |=> tx_sr_q == SLIP_ESC && tx_pend_v_q)
    else $error("reserved byte not escaped");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (int_stat_q & int_mask_q) != '0 |=> irq_q)
    else $error("interrupt output missing");

endmodule // ufbl_top

/* File: sim/ufbl_host.sv */
// Host-side serial port model facing the device pins
`timescale 1ns/1ps
module ufbl_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  // Idle line, clear to send
  initial begin
    rxd = 1'h1;
    cts_n = 1'h0;
  end
  // One 8N1 frame, LSB first, bl cycles a bit at the device's own rate
  task automatic send(input logic [7:0] b, input int bl);
    logic [9:0] w;
    w = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd <= w[i];
      repeat (bl) @(posedge ref_clk);
    end
  endtask
  // Catch a frame: mid-bit samples, and the cycle of the first high after start
  task automatic recv(input int bl, output logic [9:0] f, output int low);
    int n;
    n = 0;
    low = 0;
    while (txd !== 1'h0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    for (int t = 0; t < 10 * bl; t++) begin
      if (t % bl == bl / 2) f = {txd, f[9:1]};
      if (txd === 1'h1 && low == 0) low = t;
      @(posedge ref_clk);
    end
  endtask
endmodule // ufbl_host

/* File: sim/ufbl_top_tb.sv */
// Self-checking bench for the fractional-baud serial port
`timescale 1ns/1ps
module ufbl_top_tb import ufbl_pkg::*;;
  logic ref_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, x = 32'h5b67;
  logic [31:0] prdata, r;
  logic pready, pslverr, txd, rxd, cts_n, rts_n, irq, wake_req, e;
  logic [9:0] f;
  logic [7:0] b, cd, st;
  int bad_count = 0, n_compared = 0, bl, low;
  // Clock of 20 ns
  always #10 ref_clk = ~ref_clk;
  // Device and host
  ufbl_top dut_u (.ref_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .cts_n, .rts_n, .irq, .wake_req);
  ufbl_host host_u (.ref_clk, .txd, .rxd, .cts_n);
  // Bench helpers
  function automatic logic [31:0] rnd(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic int blen(input logic [7:0] c, input logic [7:0] s);
    return 16 * (256 - c) + (s[7:4] > 8 ? 8 : s[7:4]) + (s[3:0] > 8 ? 8 : s[3:0]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] v);
    n_compared++;
    if (s !== v) begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", nm, v, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Transmit line must stay idle while held off
  task automatic quiet(input int n);
    int q;
    q = 0;
    repeat (n) begin
      @(posedge ref_clk);
      q += (txd !== 1'h1);
    end
    chk("held", q, 0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'h0;
    apb(1'h0, ADDR_CDIV, 32'h0);
    chk("divisor", r, CLKDIV_RST);
    apb(1'h0, ADDR_STUF, 32'h0);
    chk("stuffing", r, 32'h0);
    apb(1'h0, 8'h1c, 32'h0);
    chk("unmapped", e, 1'h1);
    $display("registers done");
    for (int k = 0; k < 4; k++) begin
      x = rnd(x);
      cd = 8'hff - {7'h0, x[0]};
      st = (k == 0) ? 8'hf9 : x[15:8];
      b = x[23:16] | 8'h01;
      bl = blen(cd, st);
      apb(1'h1, ADDR_CDIV, {24'h0, cd});
      apb(1'h1, ADDR_STUF, {24'h0, st});
      fork
        apb(1'h1, ADDR_DATA, {24'h0, b});
        host_u.recv(bl, f, low);
      join
      chk("tx frame", f, {1'h1, b, 1'h0});
      chk("bit length", low, bl);
      host_u.send(~b, bl);
      repeat (8) @(posedge ref_clk);
      apb(1'h0, ADDR_DATA, 32'h0);
      chk("rx word", r, {24'h800000, ~b});
    end
    apb(1'h0, ADDR_ISTA, 32'h0);
    chk("rx event", r[I_RXB], 1'h1);
    apb(1'h1, ADDR_IMSK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("irq on", irq, 1'h1);
    apb(1'h1, ADDR_ISTA, 32'h7f);
    repeat (2) @(posedge ref_clk);
    chk("irq off", irq, 1'h0);
    $display("serial loop done");
    apb(1'h1, ADDR_CTRL, 32'h2);
    host_u.send(CH_XOFF, bl);
    repeat (8) @(posedge ref_clk);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("paused", r[2:0], 3'h5);
    apb(1'h1, ADDR_DATA, 32'h55);
    quiet(3 * bl);
    fork
      host_u.send(CH_XON, bl);
      host_u.recv(bl, f, low);
    join
    chk("resumed", f, {1'h1, 8'h55, 1'h0});
    apb(1'h1, ADDR_CTRL, 32'h8);
    fork
      apb(1'h1, ADDR_DATA, {24'h0, SLIP_END});
      begin
        host_u.recv(bl, f, low);
        chk("escape", f, {1'h1, SLIP_ESC, 1'h0});
        host_u.recv(bl, f, low);
        chk("escaped end", f, {1'h1, SLIP_EEND, 1'h0});
      end
    join
    host_u.send(SLIP_END, bl);
    repeat (8) @(posedge ref_clk);
    apb(1'h0, ADDR_DATA, 32'h0);
    chk("frame end", r, {24'h800001, SLIP_END});
    $display("xoff and slip done");
    apb(1'h1, ADDR_CTRL, 32'h4);
    chk("rts low", rts_n, 1'h0);
    host_u.cts_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
    apb(1'h1, ADDR_DATA, 32'h3c);
    quiet(3 * bl);
    host_u.cts_n <= 1'h0;
    host_u.recv(bl, f, low);
    chk("after cts", f, {1'h1, 8'h3c, 1'h0});
    apb(1'h1, ADDR_CTRL, 32'h10);
    chk("asleep", wake_req, 1'h0);
    host_u.cts_n <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk("woken", wake_req, 1'h1);
    host_u.cts_n <= 1'h0;
    apb(1'h1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("awake", wake_req, 1'h0);
    $display("flow and wake done");
    apb(1'h1, ADDR_CTRL, 32'h1);
    host_u.send(8'h55, 80);
    repeat (1000) @(posedge ref_clk);
    apb(1'h0, ADDR_CDIV, 32'h0);
    chk("detected rate", r, 32'(256 - 80 / 16));
    host_u.send(8'ha5, 80);
    repeat (8) @(posedge ref_clk);
    apb(1'h0, ADDR_DATA, 32'h0);
    chk("rate rx", r, 32'h800000a5);
    $display("rate detection done");
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
endmodule // ufbl_top_tb
